// ### hw/cdo_option_regs.sv
// Cache and DRAM option registers with their cycle-level effects
//
// Overview of operation
// - SRAM test bit forces every cycle a hit
// - Test mode: ready one clock after strobe
// - Option bit 7 slows refresh one in four
// - Option bit 5 picks flush or interrupt
// - Option bit 4 picks identification or turbo
// - Option bit 1 delays EDO write after read 1T
// - Option bit 0 picks latch enable edge
// - Area bit 7 routes to DRAM or PCI
// - Area bit 6 enables non-cacheable area
// - Area bits 5:3 give size, 64 KB base
// - Base from bits 2:0 and next register
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module cdo_option_regs
  import cdo_pkg::*;
(
  input wire logic clk, // Processor clock, 10 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic [APB_AW-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [APB_DW-1:0] pwdata, // APB write data
  output logic [APB_DW-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic address_strobe_n, // Processor address strobe
  input wire logic [HOST_AW-1:0] hostAddr, // Processor address
  input wire logic tagHit, // Tag lookup result
  input wire logic memReadyN, // Ready from memory path
  output logic burst_ready_n, // Burst ready to processor
  output logic cacheHit, // Cycle served by cache
  output logic nonCacheable, // Cycle hit non-cacheable area
  output logic routeToPci, // Non-cacheable cycle goes to PCI
  output logic localDramSel, // Cycle goes to local DRAM
  output logic edoTestMode, // EDO test mode level
  input wire logic refreshTick, // Refresh interval pulse
  output logic refreshReq, // Paced refresh request
  input wire logic cacheFlushReq, // Flush request source
  input wire logic secondary_interrupt, // Secondary interrupt source
  output logic sharedFlushPin, // Flush or interrupt pin
  input wire logic processor_identification, // Identification source
  input wire logic turboIn, // Turbo source
  output logic sharedIdPin, // Identification or turbo pin
  input wire logic bedoReadDone, // Burst EDO read finished
  input wire logic bedoWriteReq, // Burst EDO write wanted
  output logic bedoWritePulse, // Burst EDO write pulse
  output logic mdleFallingEdge // Latch enable on falling edge
);

  // ----------------------------------------------------------------
  // Register storage and APB decode
  // ----------------------------------------------------------------
  logic [REG_W-1:0] memTest_q;
  logic [REG_W-1:0] options_q;
  logic [REG_W-1:0] ncCtrl_q;
  logic [REG_W-1:0] ncBase_q;
  logic [APB_DW-1:0] prdata_q;
  logic selTest;
  logic selOpt;
  logic selNcCtrl;
  logic selNcBase;
  logic addrHit;
  logic accessDone;
  logic wrDone;
  logic setupRead;
  logic [REG_W-1:0] wrByte;
  logic [REG_W-1:0] readByte;

  assign selTest = (paddr == ADDR_MEM_TEST);
  assign selOpt = (paddr == ADDR_OPTIONS);
  assign selNcCtrl = (paddr == ADDR_NC_CTRL);
  assign selNcBase = (paddr == ADDR_NC_BASE);
  assign addrHit = selTest || selOpt || selNcCtrl || selNcBase;
  assign accessDone = psel && penable;
  assign wrDone = accessDone && pwrite && addrHit;
  assign setupRead = psel && !penable && !pwrite;
  assign wrByte = pwdata[REG_W-1:0];
  assign readByte = selTest ? memTest_q :
                    selOpt ? options_q :
                    selNcCtrl ? ncCtrl_q :
                    selNcBase ? ncBase_q : REG_RESET;

  // Zero wait states: read data is caught in setup, answered in access
  assign pready = accessDone;
  assign pslverr = accessDone && !addrHit;
  assign prdata = prdata_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memTest_q <= REG_RESET;
      options_q <= REG_RESET;
      ncCtrl_q <= REG_RESET;
      ncBase_q <= REG_RESET;
      prdata_q <= '0;
    end else begin
      if (wrDone && selTest) memTest_q <= wrByte;
      if (wrDone && selOpt) options_q <= wrByte;
      if (wrDone && selNcCtrl) ncCtrl_q <= wrByte;
      if (wrDone && selNcBase) ncBase_q <= wrByte;
      if (setupRead) prdata_q <= {{(APB_DW-REG_W){1'b0}}, readByte};
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  logic bsramTest;
  logic slowRefresh;
  logic intrSel;
  logic turboSel;
  logic bedoDelayEn;
  logic areaToPci;
  logic areaEnable;
  logic [NC_SIZE_W-1:0] areaSize;
  logic [NC_BASE_W-1:0] areaBase;

  assign bsramTest = memTest_q[TEST_BSRAM_BIT];
  assign slowRefresh = options_q[OPT_SLOW_REFRESH_BIT];
  assign intrSel = options_q[OPT_INTR_SEL_BIT];
  assign turboSel = options_q[OPT_TURBO_SEL_BIT];
  assign bedoDelayEn = options_q[OPT_BEDO_DELAY_BIT];
  assign areaToPci = ncCtrl_q[NC_ALLOC_BIT];
  assign areaEnable = ncCtrl_q[NC_EN_BIT];
  assign areaSize = ncCtrl_q[NC_SIZE_LSB +: NC_SIZE_W];
  assign areaBase = {ncCtrl_q[NC_HI_W-1:0], ncBase_q};

  // ----------------------------------------------------------------
  // Processor cycle decisions
  // ----------------------------------------------------------------
  logic areaHit;
  logic cycleStart;
  logic burstReadyN_q;
  logic cacheHit_q;
  logic nonCacheable_q;
  logic routeToPci_q;
  logic localDramSel_q;

  cdo_noncache_match u_match (
    .hostAddr(hostAddr),
    .areaBase(areaBase),
    .sizeCode(areaSize),
    .areaEnable(areaEnable),
    .areaHit(areaHit)
  );

  assign cycleStart = !address_strobe_n;

  // Outside test mode the memory path paces ready; inside, the strobe does
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      burstReadyN_q <= 1'b1;
    end else begin
      burstReadyN_q <= bsramTest ? address_strobe_n : memReadyN;
    end
  end

  // Decisions are latched per cycle at the address strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cacheHit_q <= 1'b0;
      nonCacheable_q <= 1'b0;
      routeToPci_q <= 1'b0;
      localDramSel_q <= 1'b0;
    end else if (cycleStart) begin
      cacheHit_q <= bsramTest || (tagHit && !areaHit);
      nonCacheable_q <= areaHit;
      routeToPci_q <= areaHit && areaToPci;
      localDramSel_q <= !(areaHit && areaToPci);
    end
  end

  assign burst_ready_n = burstReadyN_q;
  assign cacheHit = cacheHit_q;
  assign nonCacheable = nonCacheable_q;
  assign routeToPci = routeToPci_q;
  assign localDramSel = localDramSel_q;
  assign edoTestMode = memTest_q[TEST_EDO_BIT];

  // ----------------------------------------------------------------
  // Refresh pacing and shared pins
  // ----------------------------------------------------------------
  cdo_refresh_pacer u_pacer (
    .clk(clk),
    .rst_b(rst_b),
    .refreshTick(refreshTick),
    .slowMode(slowRefresh),
    .refreshReq(refreshReq)
  );

  assign sharedFlushPin = intrSel ? secondary_interrupt :
                          cacheFlushReq;
  assign sharedIdPin = turboSel ? turboIn : processor_identification;
  assign mdleFallingEdge = options_q[OPT_MEMORY_DATA_LATCH_ENABLE_FALL_BIT];

  // ----------------------------------------------------------------
  // Burst EDO write after read
  // ----------------------------------------------------------------
  cdo_bedo_state_t bedoState_q;
  cdo_bedo_state_t bedoState_d;
  logic afterRead_q;
  logic bedoPulse_q;
  logic needDelay;
  logic pulseNow;

  // A write that follows a read waits one clock when the delay is on
  assign needDelay = bedoWriteReq && bedoDelayEn && afterRead_q;
  assign pulseNow = (bedoState_q == BEDO_HOLD) ||
                    (bedoWriteReq && !needDelay && bedoState_q == BEDO_IDLE);

  always_comb begin
    bedoState_d = bedoState_q;
    case (bedoState_q)
      BEDO_IDLE: begin
        if (needDelay) bedoState_d = BEDO_HOLD;
      end
      BEDO_HOLD: begin
        bedoState_d = BEDO_IDLE;
      end
      default: begin
        bedoState_d = BEDO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bedoState_q <= BEDO_IDLE;
      afterRead_q <= 1'b0;
      bedoPulse_q <= 1'b0;
    end else begin
      bedoState_q <= bedoState_d;
      bedoPulse_q <= pulseNow;
      if (bedoReadDone) afterRead_q <= 1'b1;
      else if (pulseNow) afterRead_q <= 1'b0;
    end
  end

  assign bedoWritePulse = bedoPulse_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Ticks seen since the last slow-mode request, saturating at the ratio;
  // the ratio is a power of two, so full is the top bit alone
  localparam logic [REFRESH_CNT_W:0] GAP_ZERO = {1'b0, REFRESH_CNT_ZERO};
  localparam logic [REFRESH_CNT_W:0] GAP_ONE = {1'b0, REFRESH_CNT_ONE};
  localparam logic [REFRESH_CNT_W:0] GAP_FULL = {1'b1, REFRESH_CNT_ZERO};
  logic [REFRESH_CNT_W:0] tickGap_q;
  logic slowPrev_q;

  // A request caused by a normal-mode tick must not restart the gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slowPrev_q <= 1'b0;
      tickGap_q <= GAP_FULL;
    end else begin
      slowPrev_q <= slowRefresh;
      if (!slowRefresh) begin
        tickGap_q <= GAP_FULL;
      end else if (refreshReq && slowPrev_q) begin
        tickGap_q <= refreshTick ? GAP_ONE : GAP_ZERO;
      end else if (refreshTick && tickGap_q != GAP_FULL) begin
        tickGap_q <= tickGap_q + GAP_ONE;
      end
    end
  end

  chk_test_all_hit: assert property (
    (bsramTest && cycleStart) |=> cacheHit)
    else $error("test mode cycle not taken as a hit");

  chk_test_ready_next: assert property (
    (bsramTest && cycleStart) |=> !burst_ready_n)
    else $error("ready not given one clock after strobe");

  chk_test_no_ready: assert property (
    (bsramTest && !cycleStart) |=> burst_ready_n)
    else $error("ready given without a strobe in test mode");

  chk_refresh_slow: assert property (
    (slowPrev_q && refreshReq) |->
    tickGap_q == GAP_FULL)
    else $error("slow refresh passed more than one tick in four");

  chk_refresh_idle: assert property (
    !refreshTick |=> !refreshReq)
    else $error("refresh request without a tick");

  chk_refresh_normal: assert property (
    (!slowRefresh && refreshTick) |=> refreshReq)
    else $error("normal refresh dropped a tick");

  chk_flush_pin_sel: assert property (
    sharedFlushPin == (options_q[OPT_INTR_SEL_BIT] ?
                       secondary_interrupt : cacheFlushReq))
    else $error("flush pin carries the wrong source");

  chk_id_pin_sel: assert property (
    sharedIdPin == (options_q[OPT_TURBO_SEL_BIT] ?
                    turboIn : processor_identification))
    else $error("identification pin carries the wrong source");

  chk_bedo_delay: assert property (
    (needDelay && bedoState_q == BEDO_IDLE) |=> !bedoWritePulse ##1
    bedoWritePulse)
    else $error("write after read not delayed by one clock");

  chk_bedo_direct: assert property (
    (bedoWriteReq && !bedoDelayEn && bedoState_q == BEDO_IDLE) |=>
    bedoWritePulse)
    else $error("undelayed write pulse missing");

  chk_memory_data_latch_enable_edge: assert property (
    $past(wrDone && selOpt) |->
    mdleFallingEdge == $past(pwdata[OPT_MEMORY_DATA_LATCH_ENABLE_FALL_BIT]))
    else $error("latch edge select not taken from write");

  chk_pci_route: assert property (
    (cycleStart && areaHit && areaToPci) |=> routeToPci && !localDramSel)
    else $error("non-cacheable cycle not routed to PCI");

  chk_local_dram: assert property (
    (cycleStart && !(areaHit && areaToPci)) |=>
    localDramSel && !routeToPci)
    else $error("cycle not routed to local DRAM");

  chk_decision_hold: assert property (
    !cycleStart |=> $stable(cacheHit) && $stable(nonCacheable) &&
    $stable(routeToPci))
    else $error("cycle decision changed without a strobe");

  chk_area_off: assert property (
    (cycleStart && !areaEnable) |=> !nonCacheable)
    else $error("disabled area marked a cycle non-cacheable");

  chk_area_mark: assert property (
    (cycleStart && areaEnable && hostAddr[HOST_AW-1:NC_ADDR_LSB] ==
     {{(HOST_AW-NC_ADDR_MSB-1){1'b0}}, areaBase}) |=> nonCacheable)
    else $error("cycle at area base not marked non-cacheable");

  chk_area_outside: assert property (
    (cycleStart && areaSize == '0 &&
     hostAddr[NC_ADDR_MSB:NC_ADDR_LSB] != areaBase) |=> !nonCacheable)
    else $error("64 KB area matched outside its base");

  chk_apb_read: assert property (
    (setupRead && selOpt) |=> prdata[REG_W-1:0] == options_q)
    else $error("read data does not match register");

endmodule

// ### include/cdo_pkg.sv
// Constants and types shared by the cache and DRAM option register block
package cdo_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MEM_TEST = 8'h54;
  localparam logic [7:0] IDX_OPTIONS = 8'h55;
  localparam logic [7:0] IDX_NC_CTRL = 8'h56;
  localparam logic [7:0] IDX_NC_BASE = 8'h57;
  localparam logic [APB_AW-1:0] ADDR_MEM_TEST = {2'h0, IDX_MEM_TEST, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_OPTIONS = {2'h0, IDX_OPTIONS, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_NC_CTRL = {2'h0, IDX_NC_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_NC_BASE = {2'h0, IDX_NC_BASE, 2'h0};
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TEST_BSRAM_BIT = 1;
  localparam int TEST_EDO_BIT = 2;
  localparam int OPT_SLOW_REFRESH_BIT = 7;
  localparam int OPT_INTR_SEL_BIT = 5;
  localparam int OPT_TURBO_SEL_BIT = 4;
  localparam int OPT_BEDO_DELAY_BIT = 1;
  localparam int OPT_MEMORY_DATA_LATCH_ENABLE_FALL_BIT = 0;
  localparam int NC_ALLOC_BIT = 7;
  localparam int NC_EN_BIT = 6;
  localparam int NC_SIZE_LSB = 3;
  localparam int NC_SIZE_W = 3;
  localparam int NC_HI_W = 3;
  localparam int NC_BASE_W = 11;
  localparam int HOST_AW = 32;
  localparam int NC_ADDR_LSB = 16;
  localparam int NC_ADDR_MSB = 26;

  // ----------------------------------------------------------------
  // Refresh slowdown
  // ----------------------------------------------------------------
  localparam int REFRESH_SLOW_RATIO = 4;
  localparam int REFRESH_CNT_W = $clog2(REFRESH_SLOW_RATIO);
  localparam logic [REFRESH_CNT_W-1:0] REFRESH_CNT_ZERO = '0;
  localparam logic [REFRESH_CNT_W-1:0] REFRESH_CNT_ONE = REFRESH_CNT_W'(1);

  typedef enum logic [1:0] {
    BEDO_IDLE = 2'b01,
    BEDO_HOLD = 2'b10
  } cdo_bedo_state_t;

endpackage

// ### hw/cdo_refresh_pacer.sv
// Refresh request pacer with optional one-in-four slowdown
`timescale 1ns/1ps
module cdo_refresh_pacer
  import cdo_pkg::*;
(
  input wire logic clk, // Processor clock
  input wire logic rst_b, // Async reset, active low
  input wire logic refreshTick, // Refresh interval pulse
  input wire logic slowMode, // Pass one tick in four
  output logic refreshReq // Refresh request pulse
);

  logic [REFRESH_CNT_W-1:0] tickCnt_q;
  logic [REFRESH_CNT_W-1:0] tickCnt_d;
  logic refreshReq_q;
  logic passTick;

  assign passTick = refreshTick &&
                    (!slowMode || tickCnt_q == REFRESH_CNT_ZERO);
  assign tickCnt_d = !slowMode ? REFRESH_CNT_ZERO :
                     refreshTick ? tickCnt_q + REFRESH_CNT_ONE : tickCnt_q;
  assign refreshReq = refreshReq_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_q <= REFRESH_CNT_ZERO;
      refreshReq_q <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      refreshReq_q <= passTick;
    end
  end

endmodule

// ### hw/cdo_noncache_match.sv
// Address compare against one non-cacheable window
`timescale 1ns/1ps
module cdo_noncache_match
  import cdo_pkg::*;
(
  input wire logic [HOST_AW-1:0] hostAddr, // Processor address
  input wire logic [NC_BASE_W-1:0] areaBase, // Base, address bits 26..16
  input wire logic [NC_SIZE_W-1:0] sizeCode, // Size code, 64 KB doubling
  input wire logic areaEnable, // Window enable
  output logic areaHit // Address falls in window
);

  logic [NC_BASE_W-1:0] bitOk;
  logic inSpace;

  // Each size step frees one more low base bit from the compare
  genvar i;
  generate
    for (i = 0; i < NC_BASE_W; i++) begin : g_bit
      assign bitOk[i] = (i < int'(sizeCode)) ||
        (hostAddr[NC_ADDR_LSB+i] == areaBase[i]);
    end
  endgenerate

  // Window lives inside the lowest 128 MB only
  assign inSpace = (hostAddr[HOST_AW-1:NC_ADDR_MSB+1] == '0);
  assign areaHit = areaEnable && inSpace && (&bitOk);

endmodule

// ### bench/cdo_host_model.sv
// Processor-bus partner: address strobes, tag result and memory ready
`timescale 1ns/1ps
module cdo_host_model
  import cdo_pkg::*;
(
  input wire logic clk, // Processor clock
  output logic address_strobe_n, // Cycle start strobe
  output logic [HOST_AW-1:0] hostAddr, // Processor address
  output logic tagHit, // Tag lookup result
  output logic memReadyN // Memory path ready
);
  initial begin
    address_strobe_n = 1'b1;
    hostAddr = '0;
    tagHit = 1'b0;
    memReadyN = 1'b1;
  end

  // Address and tag mean nothing outside the strobe; they then carry the
  // inverse, so a stale value can never pass for a fresh one
  task automatic strobe(input logic [HOST_AW-1:0] a, input logic hit);
    @(posedge clk);
    address_strobe_n <= 1'b0;
    hostAddr <= a;
    tagHit <= hit;
    @(posedge clk);
    address_strobe_n <= 1'b1;
    hostAddr <= ~a;
    tagHit <= ~hit;
  endtask

  // Memory path answers after nWait idle cycles, low for one cycle
  task automatic answer(input int nWait);
    repeat (nWait + 1) @(posedge clk);
    memReadyN <= 1'b0;
    @(posedge clk);
    memReadyN <= 1'b1;
  endtask
endmodule

// ### bench/tb_cdo_option_regs.sv
// Self-checking bench for the cache and DRAM option registers
`timescale 1ns/1ps
module tb_cdo_option_regs;
  import cdo_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic address_strobe_n, tagHit, memReadyN, burst_ready_n;
  logic [HOST_AW-1:0] hostAddr;
  logic cacheHit, nonCacheable, routeToPci, localDramSel, edoTestMode;
  logic refreshTick, refreshReq, cacheFlushReq, secondary_interrupt;
  logic sharedFlushPin, processor_identification, turboIn, sharedIdPin;
  logic bedoReadDone, bedoWriteReq, bedoWritePulse, mdleFallingEdge;
  int n_fail = 0;
  int compares = 0;
  localparam logic [APB_AW-1:0] REGS [4] = '{ADDR_MEM_TEST, ADDR_OPTIONS,
    ADDR_NC_CTRL, ADDR_NC_BASE};

  cdo_option_regs cdo_option_regs_inst (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_strobe_n(address_strobe_n), .hostAddr(hostAddr),
    .tagHit(tagHit), .memReadyN(memReadyN), .burst_ready_n(burst_ready_n),
    .cacheHit(cacheHit), .nonCacheable(nonCacheable),
    .routeToPci(routeToPci), .localDramSel(localDramSel),
    .edoTestMode(edoTestMode), .refreshTick(refreshTick),
    .refreshReq(refreshReq), .cacheFlushReq(cacheFlushReq),
    .secondary_interrupt(secondary_interrupt),
    .sharedFlushPin(sharedFlushPin),
    .processor_identification(processor_identification),
    .turboIn(turboIn), .sharedIdPin(sharedIdPin),
    .bedoReadDone(bedoReadDone), .bedoWriteReq(bedoWriteReq),
    .bedoWritePulse(bedoWritePulse), .mdleFallingEdge(mdleFallingEdge));

  cdo_host_model cdo_host_model_inst (.clk(clk),
    .address_strobe_n(address_strobe_n), .hostAddr(hostAddr),
    .tagHit(tagHit), .memReadyN(memReadyN));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string w, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %b expected %b", $time, w, got, exp);
    end
  endtask

  task automatic chk_word(input string w, input logic [31:0] got,
                          input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb(input logic [APB_AW-1:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    bit ok;
    ok = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        ok = 1;
        r = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (!ok) begin
      n_fail++;
      $display("ERROR %0t no pready", $time);
      end_sim;
    end
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [APB_AW-1:0] a, input logic [7:0] exp,
                    input logic expErr);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 8'h00, r, e);
    chk_word("read data", r, {24'h000000, exp});
    chk_bit("slave error", e, expErr);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk_bit("ready idle", burst_ready_n, 1'b1);
    chk_bit("edo idle", edoTestMode, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(REGS[i], REG_RESET, 1'b0);
      wr(REGS[i], 8'hA5 ^ i[7:0]);
      rd(REGS[i], 8'hA5 ^ i[7:0], 1'b0);
      wr(REGS[i], 8'h00);
    end
    // Area II is not in this block, so it must refuse
    wr(12'h160, 8'hFF);
    rd(12'h160, 8'h00, 1'b1);
    rd(ADDR_NC_BASE, 8'h00, 1'b0);
  endtask

  task automatic t_edo;
    wr(ADDR_MEM_TEST, 8'h05);
    chk_bit("edo on", edoTestMode, 1'b1);
    wr(ADDR_MEM_TEST, 8'h01);
    chk_bit("edo off", edoTestMode, 1'b0);
  endtask

  task automatic t_sram;
    wr(ADDR_MEM_TEST, 8'h03);
    rd(ADDR_MEM_TEST, 8'h03, 1'b0);
    cdo_host_model_inst.strobe(32'h0000_1000, 1'b0);
    #1;
    chk_bit("forced hit", cacheHit, 1'b1);
    chk_bit("test ready", burst_ready_n, 1'b0);
    @(posedge clk);
    #1;
    chk_bit("ready once", burst_ready_n, 1'b1);
    wr(ADDR_MEM_TEST, 8'h01);
    cdo_host_model_inst.strobe(32'h0000_1000, 1'b0);
    #1;
    chk_bit("real miss", cacheHit, 1'b0);
    chk_bit("no forced ready", burst_ready_n, 1'b1);
    cdo_host_model_inst.answer(3);
    #1;
    chk_bit("slow ready", burst_ready_n, 1'b0);
    cdo_host_model_inst.answer(0);
    #1;
    chk_bit("prompt ready", burst_ready_n, 1'b0);
  endtask

  task automatic t_pins;
    logic s, p;
    for (int k = 0; k < 4; k++) begin
      s = k[1];
      p = k[0];
      wr(ADDR_OPTIONS, {2'b00, s, s, 3'b010, s});
      @(posedge clk);
      cacheFlushReq <= p;
      secondary_interrupt <= !p;
      processor_identification <= p;
      turboIn <= !p;
      #1;
      chk_bit("flush pin", sharedFlushPin, s ? !p : p);
      chk_bit("id pin", sharedIdPin, s ? !p : p);
      chk_bit("latch edge", mdleFallingEdge, s);
    end
  endtask

  task automatic ticks(input int exp);
    int cnt;
    cnt = 0;
    repeat (8) begin
      @(posedge clk);
      refreshTick <= 1'b1;
      #1;
      cnt += (refreshReq === 1'b1);
      @(posedge clk);
      refreshTick <= 1'b0;
      #1;
      cnt += (refreshReq === 1'b1);
    end
    chk_word("refresh count", cnt, exp);
  endtask

  task automatic t_refresh;
    wr(ADDR_OPTIONS, 8'h04);
    ticks(8);
    wr(ADDR_OPTIONS, 8'h84);
    ticks(2);
  endtask

  task automatic bedo_lat(input logic rdFirst, input int exp);
    int lat;
    lat = 0;
    if (rdFirst) begin
      @(posedge clk);
      bedoReadDone <= 1'b1;
      @(posedge clk);
      bedoReadDone <= 1'b0;
    end
    @(posedge clk);
    bedoWriteReq <= 1'b1;
    for (int k = 1; k <= 4 && lat == 0; k++) begin
      @(posedge clk);
      bedoWriteReq <= 1'b0;
      #1;
      if (bedoWritePulse === 1'b1) lat = k;
    end
    chk_word("write pulse delay", lat, exp);
    repeat (3) @(posedge clk);
  endtask

  task automatic t_bedo;
    wr(ADDR_OPTIONS, 8'h06);
    bedo_lat(1'b1, 2);
    bedo_lat(1'b0, 1);
    wr(ADDR_OPTIONS, 8'h04);
    bedo_lat(1'b1, 1);
  endtask

  task automatic area_hit(input logic [31:0] a, input logic h,
                          input logic alloc);
    cdo_host_model_inst.strobe(a, 1'b1);
    #1;
    chk_bit("noncache", nonCacheable, h);
    chk_bit("to pci", routeToPci, h & alloc);
    chk_bit("to dram", localDramSel, !(h & alloc));
    chk_bit("cache hit", cacheHit, !h);
  endtask

  task automatic t_area;
    logic [31:0] size;
    wr(ADDR_NC_BASE, 8'h80);
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_NC_CTRL, {n[0], 1'b1, n[2:0], 3'b100});
      size = 32'h0001_0000 << n;
      area_hit(32'h0480_0000 + size - 1, 1'b1, n[0]);
      area_hit(32'h0480_0000 + size, 1'b0, n[0]);
      area_hit(32'h047F_FFFF, 1'b0, n[0]);
    end
    wr(ADDR_NC_CTRL, 8'h84);
    area_hit(32'h0480_0000, 1'b0, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, refreshTick, bedoReadDone, bedoWriteReq} = '0;
    {cacheFlushReq, secondary_interrupt} = '0;
    {processor_identification, turboIn} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_edo;
    t_sram;
    t_pins;
    t_refresh;
    t_bedo;
    t_area;
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t run limit reached", $time);
    end_sim;
  end
endmodule
